// file: timer_channel_mode_control_tb.sv
// self-checking bench for the timer channel block
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t mismatch at line %0d", $time, `__LINE__); end end
module timer_channel_mode_control_tb;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, pin_out_q, pin_oe_n, pin_timer_owned, counter_up_down, channel_irq;
    logic center_pwm_select = 1'b0, run = 1'b0, pin_req = 1'b0, count_up, pin_in, err;
    logic [15:0] counter_value;
    logic [7:0] c;
    // compare and edge pwm setups with the pin level expected after a match
    logic [7:0] cfg [8] = '{8'h5c, 8'h58, 8'h54, 8'h54, 8'h50, 8'h68, 8'h64, 8'h6c};
    logic pin_exp [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    int miscompares = 0;
    int total_checks = 0;
    tmc_channel tmc_channel_i (.*);
    tmc_pin_model tmc_pin_model_i (.*);
    always #2.5 pclk = ~pclk;
    // one apb transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= (a == `TMC_ADDR_VALUE) ? 4'h3 : 4'h1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // read then write: the legal way to clear the flag while configuring
    task automatic set_csc(input logic [7:0] v);
        apb(1'b0, `TMC_ADDR_CSC, 32'h0);
        apb(1'b1, `TMC_ADDR_CSC, {24'h0, v});
    endtask
    task automatic wait_irq(input logic e);
        int n;
        for (n = 0; n < 60 && channel_irq !== 1'b1; n++) @(negedge pclk);
        `CHK(channel_irq, e)
        @(posedge pclk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `TMC_ADDR_CSC, 32'h0);
        `CHK(rd[7:0], `TMC_CSC_RESET)
        apb(1'b1, `TMC_ADDR_CSC, 32'hff);
        apb(1'b0, `TMC_ADDR_CSC, 32'h0);
        `CHK(rd[7:0], 8'h7c)
        clk_en <= 1'b0;
        apb(1'b1, `TMC_ADDR_CSC, 32'h0);
        clk_en <= 1'b1;
        apb(1'b0, `TMC_ADDR_CSC, 32'h0);
        `CHK(rd[7:0], 8'h7c)
        apb(1'b0, 12'h010, 32'h0);
        `CHK(err, 1'b1)
        for (int i = 0; i < 5; i++) begin
            center_pwm_select <= (i == 4);
            c = {2'b00, i[1:0], 4'h4};
            set_csc(c);
            apb(1'b0, `TMC_ADDR_CONFIG, 32'h0);
            `CHK(rd[2:1], (i == 4) ? `TMC_MODE_CPWM : (i > 1) ? `TMC_MODE_EPWM : i[1:0])
        end
        center_pwm_select <= 1'b0;
        $display("register and mode test done");
        for (int e = 1; e < 4; e++) begin
            c = {4'h4, e[1:0], 2'b00};
            set_csc(c);
            pin_req <= 1'b1;
            wait_irq(e[0]);
            apb(1'b1, `TMC_ADDR_CSC, {24'h0, c});
            `CHK(channel_irq, e[0])
            set_csc(c);
            pin_req <= 1'b0;
            wait_irq(e[1]);
        end
        apb(1'b1, `TMC_ADDR_CSC, 32'h0c);
        `CHK(channel_irq, 1'b0)
        apb(1'b0, `TMC_ADDR_CSC, 32'h0);
        `CHK(rd[7:0], 8'h8c)
        set_csc(c);
        pin_req <= 1'b1;
        wait_irq(1'b1);
        apb(1'b0, `TMC_ADDR_CSC, 32'h0);
        pin_req <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, `TMC_ADDR_CSC, {24'h0, c});
        `CHK(channel_irq, 1'b1)
        set_csc(c);
        `CHK(channel_irq, 1'b0)
        $display("capture and flag test done");
        set_csc(8'h50);
        apb(1'b1, `TMC_ADDR_VALUE, 32'h5);
        for (int k = 0; k < 8; k++) begin
            set_csc(cfg[k]);
            `CHK(pin_oe_n, cfg[k][3:2] == 2'b00)
            run <= 1'b1;
            wait_irq(1'b1);
            run <= 1'b0;
            `CHK(pin_out_q, pin_exp[k])
        end
        center_pwm_select <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            c = k[1] ? 8'h54 : 8'h68;
            set_csc(c);
            run <= 1'b1;
            wait_irq(1'b1);
            run <= 1'b0;
            `CHK(pin_out_q, count_up ~^ c[2])
        end
        center_pwm_select <= 1'b0;
        apb(1'b1, `TMC_ADDR_CSC, 32'h0);
        `CHK(pin_timer_owned, 1'b0)
        `CHK(pin_oe_n, 1'b1)
        $display("compare and pwm test done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: tmc_channel.v
// timer channel status and control logic with apb register access
// Behaviour
// - capture mode: selected pin edge sets flag
// - compare or edge pwm: match sets flag
// - center pwm: every match sets flag
// - irq while flag and enable set
// - clear needs flag read then zero write
// - new event between restarts clear sequence
// - reset clears flag; writing one ignored
// - irq enable read/write, reset zero
// - high mode bit selects edge pwm
// - low mode bit: capture or compare
// - select zero releases pin from timer
// - capture edge: rising, falling or both
// - compare action: none, toggle, low, high
// - edge pwm polarity from select bits
// - center mode overrides mode bits, not polarity
// - center select makes counter up/down
// - status write resets value coherency latch
`include "tmc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module tmc_channel (
    // clock, reset and clock enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // apb register port
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // timer side: counter state and center select
    input wire center_pwm_select,
    input wire [15:0] counter_value,
    input wire count_up,
    // channel pin
    input wire pin_in,
    output reg pin_out_q,
    output wire pin_oe_n,
    output wire pin_timer_owned,
    output wire counter_up_down,
    // to the counter and the interrupt controller
    output wire channel_irq
);

    // register bits of the channel status and control register;
    // all of them clear on reset so the pin starts released
    // event flag, set by hardware, cleared by the read/zero-write pair
    reg flag_q;
    // interrupt enable, plain read/write
    reg irq_en_q;
    // mode select bits, ignored while center pwm is selected
    reg ms_high_q;
    reg ms_low_q;
    // edge/level select: capture edge, compare action or pwm polarity
    reg [1:0] els_q;
    // clear handshake state: idle or armed by a qualifying read
    reg clr_state_q;
    // next state, from the combinational process below
    reg clr_state_d;
    // previous pin sample for edge detection
    reg pin_prev_q;
    // previous counter value, to see a match only once per count
    reg [15:0] cnt_prev_q;
    // low until the first enabled clock after reset, so a match there counts
    reg cnt_seen_q;

    // bus decode; only the access phase moves register state,
    // the setup phase is used for nothing but loading read data
    wire access = psel && penable;
    wire wr_access = access && pwrite;
    wire rd_access = access && !pwrite;
    wire hit_csc = (paddr == `TMC_ADDR_CSC);
    wire hit_value = (paddr == `TMC_ADDR_VALUE);
    wire hit_config = (paddr == `TMC_ADDR_CONFIG);
    wire hit_state = (paddr == `TMC_ADDR_STATE);
    wire mapped = hit_csc || hit_value || hit_config || hit_state;
    // the status byte only changes when its lane is strobed
    wire wr_csc = wr_access && hit_csc && pstrb[0] && clk_en;
    wire rd_csc = rd_access && hit_csc && clk_en;

    // value register outputs: the compare value and the
    // byte lanes of a split write that still wait for their partner
    wire [15:0] value_q;
    wire [1:0] pending_q;

    // the slave always answers in the first access cycle;
    // no wait states are needed since every register is a flip-flop
    // and read data are loaded one cycle early
    assign pready = 1'b1;
    // unmapped addresses answer with an error, registers untouched
    assign pslverr = access && !mapped;

    // mode decode: center select overrides the per-channel mode bits;
    // the high mode bit alone picks edge pwm, whatever the low bit holds
    reg [1:0] mode;
    always @* begin
        if (center_pwm_select) begin
            mode = `TMC_MODE_CPWM;
        end else if (ms_high_q) begin
            mode = `TMC_MODE_EPWM;
        end else if (ms_low_q) begin
            // low bit alone: compare
            mode = `TMC_MODE_COMPARE;
        end else begin
            // both mode bits low: capture
            mode = `TMC_MODE_CAPTURE;
        end
    end

    // the counter runs up/down whenever center pwm is selected
    // the counter itself lives outside; this only tells it how to count
    assign counter_up_down = center_pwm_select;

    // pin is the timer's only when the select bits are nonzero; with both
    // zero it is left to general-purpose use or to clock the counter
    assign pin_timer_owned = (els_q != 2'h0);
    // active-low enable: drive only in the output modes with a nonzero select
    assign pin_oe_n = !(pin_timer_owned && (mode != `TMC_MODE_CAPTURE));

    // edge detection on the synchronous pin input; the history flop
    // resets low like the idle pin, so no false edge follows reset.
    // a pin that moves while the channel is being reconfigured can
    // still be flagged, so software clears the flag afterwards
    wire rise = pin_in && !pin_prev_q;
    wire fall = !pin_in && pin_prev_q;
    reg edge_hit;
    always @* begin
        case (els_q)
            2'h1: edge_hit = rise;
            2'h2: edge_hit = fall;
            2'h3: edge_hit = rise || fall;
            default: edge_hit = 1'b0;
        endcase
    end

    // a match is flagged only on the cycle the counter arrives at the value;
    // a held counter would otherwise re-flag every bus clock
    // the limitation: a counter stopped on the value flags only once
    wire cnt_changed = !cnt_seen_q || (counter_value != cnt_prev_q);
    wire match = (counter_value == value_q) && cnt_changed;

    // event source per mode; a released pin still lets compare
    // matches set the flag, which gives a pure software timer
    reg event_hit;
    always @* begin
        case (mode)
            `TMC_MODE_CAPTURE: event_hit = edge_hit && pin_timer_owned;
            `TMC_MODE_COMPARE: event_hit = match;
            `TMC_MODE_EPWM: event_hit = match;
            `TMC_MODE_CPWM: event_hit = match;
            default: event_hit = 1'b0;
        endcase
    end

    // capture the counter into the value register on an input edge;
    // a bus write to the value register in the same cycle wins
    wire capture_en = (mode == `TMC_MODE_CAPTURE) && event_hit;

    // value register with its byte-coherency latch
    // any status write drops a half-written value
    tmc_value_reg u_value (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .coherency_reset(wr_csc),
        .wr_en(wr_access && hit_value && clk_en),
        .wr_bytes(pstrb[1:0]),
        .wr_data(pwdata[15:0]),
        .capture_en(capture_en),
        .capture_data(counter_value),
        .value_q(value_q),
        .pending_q(pending_q)
    );

    // clear handshake next state: a read of the set flag arms it,
    // a fresh event drops it back so the earlier read no longer qualifies;
    // any status write ends the sequence, so a zero write only counts
    // once per qualifying read
    always @* begin
        clr_state_d = clr_state_q;
        case (clr_state_q)
            `TMC_CLR_IDLE: begin
                if (rd_csc && flag_q) begin
                    clr_state_d = `TMC_CLR_ARMED;
                end
            end
            `TMC_CLR_ARMED: begin
                if (event_hit) begin
                    clr_state_d = `TMC_CLR_IDLE;
                end else if (wr_csc) begin
                    clr_state_d = `TMC_CLR_IDLE;
                end
            end
            // unreachable with one state bit, kept for safety
            default: clr_state_d = `TMC_CLR_IDLE;
        endcase
    end

    // zero written to the flag after a qualifying read;
    // a one in the flag position never clears and never sets
    wire clear_ok = wr_csc && (clr_state_q == `TMC_CLR_ARMED) && !pwdata[`TMC_BIT_FLAG];

    // status and control register; set wins over clear, so an event
    // that meets the clearing write keeps the flag and its request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
            irq_en_q <= 1'b0;
            ms_high_q <= 1'b0;
            ms_low_q <= 1'b0;
            els_q <= 2'h0;
            clr_state_q <= `TMC_CLR_IDLE;
        end else if (clk_en) begin
            clr_state_q <= clr_state_d;
            if (event_hit) begin
                flag_q <= 1'b1;
            end else if (clear_ok) begin
                flag_q <= 1'b0;
            end
            // a one written to the flag is simply dropped
            // the other control bits load as one byte
            if (wr_csc) begin
                irq_en_q <= pwdata[`TMC_BIT_IRQ_EN];
                ms_high_q <= pwdata[`TMC_BIT_MS_HIGH];
                ms_low_q <= pwdata[`TMC_BIT_MS_LOW];
                els_q <= pwdata[`TMC_BIT_ELS_HI:`TMC_BIT_ELS_LO];
            end
        end
    end

    // interrupt request is a plain level of flag and enable;
    // it stays up until software clears the flag or the enable
    assign channel_irq = flag_q && irq_en_q;

    // pin sampling and counter history; the history only moves while
    // the clock enable is high, so a pin that moved while frozen shows an edge on wake
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_q <= 1'b0;
            cnt_prev_q <= 16'h0000;
            cnt_seen_q <= 1'b0;
        end else if (clk_en) begin
            pin_prev_q <= pin_in;
            cnt_prev_q <= counter_value;
            cnt_seen_q <= 1'b1;
        end
    end

    // output pin action on a match; nothing moves while the pin is
    // released, so a later return to the timer starts from the old level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_q <= 1'b0;
        end else if (clk_en && match && pin_timer_owned) begin
            case (mode)
                `TMC_MODE_COMPARE: begin
                    case (els_q)
                        2'h1: pin_out_q <= !pin_out_q;
                        2'h2: pin_out_q <= 1'b0;
                        2'h3: pin_out_q <= 1'b1;
                        default: pin_out_q <= pin_out_q;
                    endcase
                end
                `TMC_MODE_EPWM: begin
                    // high-true clears on match, low-true sets
                    pin_out_q <= els_q[0];
                end
                `TMC_MODE_CPWM: begin
                    // up-count match ends the pulse; down-count match starts it
                    // (for low-true pulses the levels are swapped)
                    if (count_up) begin
                        pin_out_q <= els_q[0];
                    end else begin
                        pin_out_q <= !els_q[0];
                    end
                end
                default: pin_out_q <= pin_out_q;
            endcase
        end
    end

    // read mux; low two status bits read zero.
    // unmapped addresses load zero here and answer with an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            // data is loaded in the setup cycle so it is stable in the access cycle
            // a write setup leaves the last read data untouched
            case (paddr)
                `TMC_ADDR_CSC: prdata <= {24'h000000, flag_q, irq_en_q, ms_high_q, ms_low_q,
                    els_q, 2'h0};
                `TMC_ADDR_VALUE: prdata <= {16'h0000, value_q};
                `TMC_ADDR_CONFIG: prdata <= {28'h0000000, center_pwm_select, mode, pin_out_q};
                `TMC_ADDR_STATE: prdata <= {28'h0000000, pending_q, clr_state_q,
                    channel_irq};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: tmc_channel_sva.sv
// port-level assertion checker for the timer channel block
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.vh"
module tmc_channel_sva (
    input wire logic pclk, presetn, clk_en, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    input wire logic pready, pslverr, center_pwm_select, count_up, pin_in,
    input wire logic [15:0] counter_value,
    input wire logic pin_out_q, pin_oe_n, pin_timer_owned, counter_up_down, channel_irq
);
    // status write that lands, and status read setup
    wire logic csc_wr = psel && penable && pwrite && clk_en && paddr == `TMC_ADDR_CSC && pstrb[0];
    wire logic csc_rd = psel && !penable && !pwrite && clk_en && paddr == `TMC_ADDR_CSC;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_now: assert property (psel && penable |-> pready) else $error("pready low");
    a_irq_hold: assert property (channel_irq && !csc_wr |=> channel_irq)
        else $error("irq dropped without status write");
    a_irq_disable: assert property (csc_wr && !pwdata[6] |=> !channel_irq)
        else $error("irq with enable cleared");
    a_updown_follow: assert property (counter_up_down == center_pwm_select)
        else $error("counter mode differs from center select");
    a_pin_release: assert property (csc_wr && pwdata[3:2] == 2'b00
        |=> !pin_timer_owned && pin_oe_n)
        else $error("pin kept with select zero");
    a_pin_owned: assert property (csc_wr && pwdata[3:2] != 2'b00 |=> pin_timer_owned)
        else $error("pin not taken with select set");
    a_drive_owned: assert property (!pin_oe_n |-> pin_timer_owned)
        else $error("pin driven while released");
    a_pin_quiet: assert property (!pin_timer_owned |=> $stable(pin_out_q))
        else $error("released pin level moved");
    a_low_bits: assert property (csc_rd |=> prdata[1:0] == 2'b00)
        else $error("low status bits not zero");
endmodule
bind tmc_channel tmc_channel_sva tmc_channel_sva_i (.*);
`default_nettype wire

// file: tmc_consts.vh
// register offsets, field positions, reset values and encodings for the timer channel block
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH

// register byte addresses (word aligned)
`define TMC_ADDR_CSC 12'h000
`define TMC_ADDR_VALUE 12'h004
`define TMC_ADDR_CONFIG 12'h008
`define TMC_ADDR_STATE 12'h00c

// channel status and control field positions
`define TMC_BIT_FLAG 7
`define TMC_BIT_IRQ_EN 6
`define TMC_BIT_MS_HIGH 5
`define TMC_BIT_MS_LOW 4
`define TMC_BIT_ELS_HI 3
`define TMC_BIT_ELS_LO 2

// reset values
`define TMC_CSC_RESET 8'h00
`define TMC_VALUE_RESET 16'h0000

// channel mode encodings
`define TMC_MODE_CAPTURE 2'h0
`define TMC_MODE_COMPARE 2'h1
`define TMC_MODE_EPWM 2'h2
`define TMC_MODE_CPWM 2'h3

// clear handshake states
`define TMC_CLR_IDLE 1'b0
`define TMC_CLR_ARMED 1'b1

`endif

// file: tmc_pin_model.sv
// far-side model: main counter and channel pin driver
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_model #(parameter int MOD = 15) (
    input wire logic pclk, presetn, run, center_pwm_select, pin_req,
    output logic [15:0] counter_value,
    output logic count_up, pin_in
);
    // pin moves only on request so it stays settled around mode changes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= 16'h0000;
            count_up <= 1'b1;
            pin_in <= 1'b0;
        end else begin
            pin_in <= pin_req;
            if (!center_pwm_select) begin
                count_up <= 1'b1;
                if (run)
                    counter_value <= (counter_value == 16'(MOD)) ? 16'h0000 : counter_value + 16'h0001;
            end else if (run) begin
                // up/down counting turns round at either end
                if (count_up ? counter_value == 16'(MOD) : counter_value == 16'h0000) begin
                    count_up <= !count_up;
                    counter_value <= count_up ? counter_value - 16'h0001 : 16'h0001;
                end else begin
                    counter_value <= count_up ? counter_value + 16'h0001 : counter_value - 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tmc_value_reg.v
// channel value register with byte-coherency latch
`timescale 1ns/1ps
`default_nettype none

module tmc_value_reg (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire coherency_reset,
    input wire wr_en,
    input wire [1:0] wr_bytes,
    input wire [15:0] wr_data,
    input wire capture_en,
    input wire [15:0] capture_data,
    output reg [15:0] value_q,
    output reg [1:0] pending_q
);

    // byte buffer holding the first half of a split write
    reg [15:0] buffer_q;

    // a split write lands only once both bytes arrived, so the compare never sees half a value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= `TMC_VALUE_RESET;
            buffer_q <= `TMC_VALUE_RESET;
            pending_q <= 2'h0;
        end else if (clk_en) begin
            if (coherency_reset) begin
                // forget any half-written value
                pending_q <= 2'h0;
            end else if (wr_en) begin
                if ((pending_q | wr_bytes) == 2'h3) begin
                    value_q[15:8] <= wr_bytes[1] ? wr_data[15:8] : buffer_q[15:8];
                    value_q[7:0] <= wr_bytes[0] ? wr_data[7:0] : buffer_q[7:0];
                    pending_q <= 2'h0;
                end else begin
                    if (wr_bytes[1]) begin
                        buffer_q[15:8] <= wr_data[15:8];
                    end
                    if (wr_bytes[0]) begin
                        buffer_q[7:0] <= wr_data[7:0];
                    end
                    pending_q <= pending_q | wr_bytes;
                end
            end else if (capture_en) begin
                // capture overwrites the stored value
                value_q <= capture_data;
            end
        end
    end

endmodule

`default_nettype wire
